// *** hdl/aip_pkg.sv ***
// Constants, types and register map of the audio input path control block
// What this block does
// - Separate left and right microphone capture enables
// - Both microphones share one data input
// - Drive microphone clock of about 2 MHz
// - Level control off: volume from volume registers
// - Level control on: volume from level control
// - Samples are 24-bit two's complement
// - Each converter runs only while enabled
// - Polarity field inverts left, right or both
// - Ratio bit picks 64x or 128x oversampling
// - Mode bit: first order fixed, second programmable
// - Three-bit cutoff field sets programmable cutoff
// - Bias voltage from level field and mode
// - Level field: off, 0.75, 0.9, 0.5 supply
// - Mode bit adds series resistor on bias
// - Unpowered disabled outputs count as unused
// - Input unused only when all switches open
// - Unused outputs tie to mid-supply automatically
// - Filter disable bit bypasses the high-pass filter
package aip_pkg;

  // ----------------------------------------
  // Register indexes (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [6:0] IDX_POL_FILT = 7'h05;
  localparam logic [6:0] IDX_BIAS_ADC = 7'h06;
  localparam logic [6:0] IDX_LEVEL_CTRL = 7'h0c;
  localparam logic [6:0] IDX_SAMPLE_RATE = 7'h27;
  localparam logic [6:0] IDX_HPF_OSR = 7'h2e;
  localparam logic [6:0] IDX_VOL_LEFT = 7'h2f;
  localparam logic [6:0] IDX_VOL_RIGHT = 7'h30;
  localparam logic [6:0] IDX_BIAS_MODE = 7'h5a;
  localparam logic [6:0] IDX_DMIC_EN = 7'h68;
  localparam logic [6:0] IDX_REF_BUF = 7'h71;
  localparam logic [6:0] IDX_PIN_CTRL = 7'h7d;
  localparam logic [6:0] IDX_STATUS = 7'h7e;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int HPD_BIT = 0;
  localparam int POL_LSB = 5;
  localparam int BIAS_LSB = 0;
  localparam int ADC_RIGHT_BIT = 2;
  localparam int ADC_LEFT_BIT = 3;
  localparam int LEVEL_EN_LSB = 7;
  localparam int RATE_LSB = 1;
  localparam int OSR_BIT = 3;
  localparam int CUT_LSB = 4;
  localparam int HPF_MODE_BIT = 7;
  localparam int VOL_UPDATE_BIT = 8;
  localparam int BIAS_MODE_BIT = 4;
  localparam int DMIC_LEFT_BIT = 4;
  localparam int DMIC_RIGHT_BIT = 5;
  localparam int REF_BUF_BIT = 8;
  localparam int CLK_PIN_SEL_BIT = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [8:0] RST_REG = 9'h000;
  localparam logic [8:0] RST_VOL = 9'h0ff;

  // ----------------------------------------
  // Microphone clock timing
  // ----------------------------------------
  localparam int CORE_FREQ_KHZ = 125000;
  localparam int DMIC_FREQ_KHZ = 2000;
  localparam int DMIC_HALF_CYCLES = CORE_FREQ_KHZ / (2 * DMIC_FREQ_KHZ);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    AIP_BIAS_OFF = 2'h0,
    AIP_BIAS_075 = 2'h1,
    AIP_BIAS_090 = 2'h2,
    AIP_BIAS_050 = 2'h3
  } aip_bias_level_t;

  typedef struct packed {
    aip_bias_level_t level;
    logic series_res;
  } aip_bias_cfg_t;

  typedef struct packed {
    logic hpf_enable;
    logic hpf_second_order;
    logic [2:0] hpf_cutoff;
    logic [2:0] sample_rate;
    logic osr_128;
  } aip_filter_cfg_t;

endpackage : aip_pkg

// *** hdl/aip_input_path.sv ***
// Audio input path control: registers, digital microphone link and tie-off logic
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module aip_input_path #(
  parameter int NUM_OUT = 4,
  parameter int NUM_IN = 4,
  parameter int SW_PER_IN = 4,
  parameter int SAMPLE_W = 24
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [31:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Digital microphone pins
  input wire logic i_dmic_data_pin,
  output logic o_dmic_clock_out,
  output logic o_dmic_clock_oe,
  // Captured microphone bits
  output logic o_left_pdm_bit,
  output logic o_left_pdm_valid,
  output logic o_right_pdm_bit,
  output logic o_right_pdm_valid,
  // Converter sample path
  input wire logic i_sample_valid,
  input wire logic [SAMPLE_W-1:0] i_left_sample,
  input wire logic [SAMPLE_W-1:0] i_right_sample,
  output logic [SAMPLE_W-1:0] o_left_sample,
  output logic [SAMPLE_W-1:0] o_right_sample,
  output logic o_sample_valid,
  // Converter and filter control
  output logic o_left_adc_run,
  output logic o_right_adc_run,
  output aip_pkg::aip_filter_cfg_t o_filter_cfg,
  // Volume
  input wire logic [7:0] i_alc_left_volume,
  input wire logic [7:0] i_alc_right_volume,
  output logic [7:0] o_left_volume,
  output logic [7:0] o_right_volume,
  // Bias and tie-off
  output aip_pkg::aip_bias_cfg_t o_bias_cfg,
  output logic o_ref_buffer_enable,
  input wire logic [NUM_OUT-1:0] i_output_powered,
  input wire logic [NUM_IN*SW_PER_IN-1:0] i_input_switch_closed,
  output logic [NUM_OUT-1:0] o_output_tie,
  output logic [NUM_IN-1:0] o_input_tie
);

  localparam int HALF = aip_pkg::DMIC_HALF_CYCLES;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [8:0] merge(input logic [8:0] old, input logic [31:0] dat,
                                       input logic [3:0] sel);
    logic [8:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[8] = dat[8];
    end
    return res;
  endfunction : merge

  // Two's complement negation that saturates the most negative code
  function automatic logic [SAMPLE_W-1:0] negate(input logic [SAMPLE_W-1:0] x);
    logic [SAMPLE_W-1:0] min_code;
    min_code = {1'b1, {(SAMPLE_W-1){1'b0}}};
    if (x == min_code) begin
      return ~min_code;
    end
    return (~x) + {{(SAMPLE_W-1){1'b0}}, 1'b1};
  endfunction : negate

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic req;
  logic wr_take;
  logic [6:0] idx;
  logic in_range;

  assign req = i_wb_cyc && i_wb_stb;
  assign idx = i_wb_adr[8:2];
  assign in_range = (i_wb_adr[31:9] == 23'h000000) && (i_wb_adr[1:0] == 2'h0);
  assign wr_take = req && i_wb_we && o_wb_ack && in_range;

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= req && !o_wb_ack;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [8:0] pol_filt;
  logic [8:0] bias_adc;
  logic [8:0] level_ctrl;
  logic [8:0] rate_sel;
  logic [8:0] hpf_osr;
  logic [8:0] vol_left;
  logic [8:0] vol_right;
  logic [8:0] bias_mode;
  logic [8:0] dmic_en;
  logic [8:0] ref_buf;
  logic [8:0] pin_ctrl;
  logic [7:0] vol_left_applied;
  logic [7:0] vol_right_applied;
  logic [8:0] status;

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      pol_filt <= aip_pkg::RST_REG;
      bias_adc <= aip_pkg::RST_REG;
      level_ctrl <= aip_pkg::RST_REG;
      rate_sel <= aip_pkg::RST_REG;
      hpf_osr <= aip_pkg::RST_REG;
      vol_left <= aip_pkg::RST_VOL;
      vol_right <= aip_pkg::RST_VOL;
      bias_mode <= aip_pkg::RST_REG;
      dmic_en <= aip_pkg::RST_REG;
      ref_buf <= aip_pkg::RST_REG;
      pin_ctrl <= aip_pkg::RST_REG;
    end else if (wr_take) begin
      case (idx)
        aip_pkg::IDX_POL_FILT: pol_filt <= merge(pol_filt, i_wb_dat, i_wb_sel);
        aip_pkg::IDX_BIAS_ADC: bias_adc <= merge(bias_adc, i_wb_dat, i_wb_sel);
        aip_pkg::IDX_LEVEL_CTRL: level_ctrl <= merge(level_ctrl, i_wb_dat, i_wb_sel);
        aip_pkg::IDX_SAMPLE_RATE: rate_sel <= merge(rate_sel, i_wb_dat, i_wb_sel);
        aip_pkg::IDX_HPF_OSR: hpf_osr <= merge(hpf_osr, i_wb_dat, i_wb_sel);
        aip_pkg::IDX_VOL_LEFT: vol_left <= merge(vol_left, i_wb_dat, i_wb_sel);
        aip_pkg::IDX_VOL_RIGHT: vol_right <= merge(vol_right, i_wb_dat, i_wb_sel);
        aip_pkg::IDX_BIAS_MODE: bias_mode <= merge(bias_mode, i_wb_dat, i_wb_sel);
        aip_pkg::IDX_DMIC_EN: dmic_en <= merge(dmic_en, i_wb_dat, i_wb_sel);
        aip_pkg::IDX_REF_BUF: ref_buf <= merge(ref_buf, i_wb_dat, i_wb_sel);
        aip_pkg::IDX_PIN_CTRL: pin_ctrl <= merge(pin_ctrl, i_wb_dat, i_wb_sel);
        default: ;
      endcase
    end
  end

  // Staged gains go live together on a write carrying the update bit
  logic vol_update;
  assign vol_update = wr_take && i_wb_sel[1] && i_wb_dat[aip_pkg::VOL_UPDATE_BIT] &&
                      ((idx == aip_pkg::IDX_VOL_LEFT) || (idx == aip_pkg::IDX_VOL_RIGHT));

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      vol_left_applied <= aip_pkg::RST_VOL[7:0];
      vol_right_applied <= aip_pkg::RST_VOL[7:0];
    end else if (vol_update) begin
      vol_left_applied <= (idx == aip_pkg::IDX_VOL_LEFT && i_wb_sel[0]) ?
                          i_wb_dat[7:0] : vol_left[7:0];
      vol_right_applied <= (idx == aip_pkg::IDX_VOL_RIGHT && i_wb_sel[0]) ?
                           i_wb_dat[7:0] : vol_right[7:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_wb_dat <= 32'h00000000;
    end else if (req && !o_wb_ack) begin
      o_wb_dat <= 32'h00000000;
      if (in_range) begin
        case (idx)
          aip_pkg::IDX_POL_FILT: o_wb_dat[8:0] <= pol_filt;
          aip_pkg::IDX_BIAS_ADC: o_wb_dat[8:0] <= bias_adc;
          aip_pkg::IDX_LEVEL_CTRL: o_wb_dat[8:0] <= level_ctrl;
          aip_pkg::IDX_SAMPLE_RATE: o_wb_dat[8:0] <= rate_sel;
          aip_pkg::IDX_HPF_OSR: o_wb_dat[8:0] <= hpf_osr;
          aip_pkg::IDX_VOL_LEFT: o_wb_dat[8:0] <= {1'b0, vol_left[7:0]};
          aip_pkg::IDX_VOL_RIGHT: o_wb_dat[8:0] <= {1'b0, vol_right[7:0]};
          aip_pkg::IDX_BIAS_MODE: o_wb_dat[8:0] <= bias_mode;
          aip_pkg::IDX_DMIC_EN: o_wb_dat[8:0] <= dmic_en;
          aip_pkg::IDX_REF_BUF: o_wb_dat[8:0] <= ref_buf;
          aip_pkg::IDX_PIN_CTRL: o_wb_dat[8:0] <= pin_ctrl;
          aip_pkg::IDX_STATUS: o_wb_dat[8:0] <= status;
          default: o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Converter, filter, bias and volume control
  // ----------------------------------------
  logic level_en;
  assign level_en = |level_ctrl[aip_pkg::LEVEL_EN_LSB +: 2];

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_left_adc_run <= 1'b0;
      o_right_adc_run <= 1'b0;
      o_filter_cfg <= '0;
      o_bias_cfg <= '{level: aip_pkg::AIP_BIAS_OFF, series_res: 1'b0};
      o_ref_buffer_enable <= 1'b0;
    end else begin
      o_left_adc_run <= bias_adc[aip_pkg::ADC_LEFT_BIT];
      o_right_adc_run <= bias_adc[aip_pkg::ADC_RIGHT_BIT];
      o_filter_cfg.hpf_enable <= !pol_filt[aip_pkg::HPD_BIT];
      o_filter_cfg.hpf_second_order <= hpf_osr[aip_pkg::HPF_MODE_BIT];
      o_filter_cfg.hpf_cutoff <= hpf_osr[aip_pkg::CUT_LSB +: 3];
      o_filter_cfg.sample_rate <= rate_sel[aip_pkg::RATE_LSB +: 3];
      o_filter_cfg.osr_128 <= hpf_osr[aip_pkg::OSR_BIT];
      o_bias_cfg.level <= aip_pkg::aip_bias_level_t'(bias_adc[aip_pkg::BIAS_LSB +: 2]);
      o_bias_cfg.series_res <= bias_mode[aip_pkg::BIAS_MODE_BIT];
      o_ref_buffer_enable <= ref_buf[aip_pkg::REF_BUF_BIT];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_left_volume <= aip_pkg::RST_VOL[7:0];
      o_right_volume <= aip_pkg::RST_VOL[7:0];
    end else if (level_en) begin
      o_left_volume <= i_alc_left_volume;
      o_right_volume <= i_alc_right_volume;
    end else begin
      o_left_volume <= vol_left_applied;
      o_right_volume <= vol_right_applied;
    end
  end

  // ----------------------------------------
  // Sample path: polarity and converter enables
  // ----------------------------------------
  logic pol_left;
  logic pol_right;
  assign pol_left = pol_filt[aip_pkg::POL_LSB];
  assign pol_right = pol_filt[aip_pkg::POL_LSB + 1];

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_left_sample <= '0;
      o_right_sample <= '0;
      o_sample_valid <= 1'b0;
    end else begin
      o_sample_valid <= i_sample_valid && (o_left_adc_run || o_right_adc_run);
      if (i_sample_valid) begin
        o_left_sample <= !o_left_adc_run ? '0 :
                         (pol_left ? negate(i_left_sample) : i_left_sample);
        o_right_sample <= !o_right_adc_run ? '0 :
                          (pol_right ? negate(i_right_sample) : i_right_sample);
      end
    end
  end

  // ----------------------------------------
  // Digital microphone link
  // ----------------------------------------
  logic data_meta;
  logic data_sync;
  logic dmic_run;
  logic [7:0] div_cnt;
  logic half_done;
  logic rise_evt;
  logic fall_evt;

  assign dmic_run = dmic_en[aip_pkg::DMIC_LEFT_BIT] || dmic_en[aip_pkg::DMIC_RIGHT_BIT];
  assign half_done = dmic_run && (div_cnt == 8'(HALF - 1));
  assign rise_evt = half_done && !o_dmic_clock_out;
  assign fall_evt = half_done && o_dmic_clock_out;

  // Both microphones drive the one data pin; sync it before use
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      data_meta <= 1'b0;
      data_sync <= 1'b0;
    end else begin
      data_meta <= i_dmic_data_pin;
      data_sync <= data_meta;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      div_cnt <= 8'h00;
      o_dmic_clock_out <= 1'b0;
      o_dmic_clock_oe <= 1'b0;
    end else begin
      o_dmic_clock_oe <= pin_ctrl[aip_pkg::CLK_PIN_SEL_BIT];
      if (!dmic_run) begin
        div_cnt <= 8'h00;
        o_dmic_clock_out <= 1'b0;
      end else if (half_done) begin
        div_cnt <= 8'h00;
        o_dmic_clock_out <= !o_dmic_clock_out;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_left_pdm_bit <= 1'b0;
      o_left_pdm_valid <= 1'b0;
      o_right_pdm_bit <= 1'b0;
      o_right_pdm_valid <= 1'b0;
    end else begin
      o_left_pdm_valid <= rise_evt && dmic_en[aip_pkg::DMIC_LEFT_BIT];
      o_right_pdm_valid <= fall_evt && dmic_en[aip_pkg::DMIC_RIGHT_BIT];
      if (rise_evt) begin
        o_left_pdm_bit <= data_sync ^ pol_left;
      end
      if (fall_evt) begin
        o_right_pdm_bit <= data_sync ^ pol_right;
      end
    end
  end

  // ----------------------------------------
  // Tie-off detection, always active
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_output_tie <= '1;
    end else begin
      o_output_tie <= ~i_output_powered;
    end
  end

  generate
    for (genvar g = 0; g < NUM_IN; g++) begin : g_in_tie
      always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
          o_input_tie[g] <= 1'b1;
        end else begin
          o_input_tie[g] <= ~|i_input_switch_closed[g*SW_PER_IN +: SW_PER_IN];
        end
      end
    end
  endgenerate

  assign status = {6'h00, |o_input_tie, |o_output_tie, dmic_run};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  localparam int HALF_M1 = HALF - 1;
  logic [7:0] hold_cnt;
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || !dmic_run) begin
      // One behind, so the first half after enable counts like the rest
      hold_cnt <= 8'hff;
    end else if (o_dmic_clock_out != $past(o_dmic_clock_out)) begin
      hold_cnt <= 8'h00;
    end else begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end

  a_wb_ack_pulse: assert property (req && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not a single cycle answer");
  a_clk_idle_off: assert property (!dmic_run |=> !o_dmic_clock_out ##1 !o_dmic_clock_out)
    else $error("mic clock runs with both channels off");
  a_clk_half_period: assert property ($changed(o_dmic_clock_out) && $past(dmic_run) &&
                                      $past(dmic_run, 2) |->
                                      hold_cnt == 8'(HALF_M1))
    else $error("mic clock half period wrong");
  a_left_on_rise: assert property (o_left_pdm_valid |-> $rose(o_dmic_clock_out))
    else $error("left bit not taken on rising clock");
  a_right_on_fall: assert property (o_right_pdm_valid |-> $fell(o_dmic_clock_out))
    else $error("right bit not taken on falling clock");
  a_adc_left_on: assert property (wr_take && idx == aip_pkg::IDX_BIAS_ADC && i_wb_sel[0]
                                  |=> ##1 o_left_adc_run == $past(i_wb_dat[3], 2))
    else $error("left converter enable not followed");
  a_pol_left_inv: assert property (i_sample_valid && o_left_adc_run && pol_left &&
                                   i_left_sample == 24'h123456 |=> o_left_sample == 24'hedcbaa)
    else $error("left polarity inversion wrong");
  a_vol_level_ctl: assert property (level_en |=> o_left_volume == $past(i_alc_left_volume))
    else $error("volume not from level control");
  a_vol_register: assert property (!level_en |=> o_left_volume == $past(vol_left_applied))
    else $error("volume not from volume register");
  a_bias_series: assert property (wr_take && idx == aip_pkg::IDX_BIAS_MODE && i_wb_sel[0]
                                  |=> ##1 o_bias_cfg.series_res == $past(i_wb_dat[4], 2))
    else $error("bias series resistor not following mode");
  a_out_unused_tie: assert property (!i_output_powered[0] |=> o_output_tie[0])
    else $error("unpowered output not tied");

  c_left_capture: cover property (o_left_pdm_valid);
  c_right_capture: cover property (o_right_pdm_valid);
  c_vol_update: cover property (vol_update);
  c_sample_out: cover property (o_sample_valid && pol_right);

endmodule : aip_input_path

// *** testbench/aip_dmic_model.sv ***
// Behavioural pair of digital microphones sharing one data line
`timescale 1ns/1ns
module aip_dmic_model (
  // Link pins
  input wire logic i_clk,
  input wire logic i_clk_en,
  output logic o_data,
  // Bits currently on offer
  output logic o_left_bit,
  output logic o_right_bit
);
  logic [7:0] left_pat = 8'hb2;
  logic [7:0] right_pat = 8'h6c;
  logic last = 1'b0;
  assign o_left_bit = left_pat[7];
  assign o_right_bit = right_pat[7];
  // --------------------------------------------
  // Left talks while clock low, right while high
  // --------------------------------------------
  always @(negedge i_clk) left_pat <= {left_pat[6:0], left_pat[7]};
  always @(posedge i_clk) right_pat <= {right_pat[6:0], right_pat[7]};
  // Undriven line shows the inverse of the last bit, never a held value
  always @* begin
    if (i_clk_en) begin
      o_data = i_clk ? o_right_bit : o_left_bit;
      last = o_data;
    end else begin
      o_data = ~last;
    end
  end
endmodule : aip_dmic_model

// *** testbench/test_audio_adc_input_path_control.sv ***
// Self-checking bench for the audio input path control block
`timescale 1ns/1ns
module test_audio_adc_input_path_control;
  logic i_core_clk, i_reset_n, cyc, stb, we, sv, ack, dpin, dclk, doe;
  logic lbit, lval, rbit, rval, osv, lrun, rrun, refb, ml, mr;
  logic [31:0] adr, wdat, rdat, q;
  logic [3:0] sel, pwr, otie, itie;
  logic [23:0] lin, rin, lout, rout;
  logic [7:0] alc_l, alc_r, lvol, rvol;
  logic [15:0] sw;
  aip_pkg::aip_filter_cfg_t fcfg;
  aip_pkg::aip_bias_cfg_t bcfg;
  int n_errors = 0, total_checks = 0, cycles = 0, n_l, n_r, n_hi;

  aip_input_path i_aip_input_path (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_dmic_data_pin(dpin),
    .o_dmic_clock_out(dclk), .o_dmic_clock_oe(doe), .o_left_pdm_bit(lbit),
    .o_left_pdm_valid(lval), .o_right_pdm_bit(rbit), .o_right_pdm_valid(rval),
    .i_sample_valid(sv), .i_left_sample(lin), .i_right_sample(rin), .o_left_sample(lout),
    .o_right_sample(rout), .o_sample_valid(osv), .o_left_adc_run(lrun),
    .o_right_adc_run(rrun), .o_filter_cfg(fcfg), .i_alc_left_volume(alc_l),
    .i_alc_right_volume(alc_r), .o_left_volume(lvol), .o_right_volume(rvol),
    .o_bias_cfg(bcfg), .o_ref_buffer_enable(refb), .i_output_powered(pwr),
    .i_input_switch_closed(sw), .o_output_tie(otie), .o_input_tie(itie));
  aip_dmic_model i_aip_dmic_model (.i_clk(dclk), .i_clk_en(doe), .o_data(dpin),
    .o_left_bit(ml), .o_right_bit(mr));

  // --------------------------------------------
  // Access and compare tasks
  // --------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step
  function automatic logic [31:0] a4(input logic [6:0] i);
    return {23'h000000, i, 2'h0};
  endfunction : a4
  task automatic wb(input logic w, input logic [31:0] a, input logic [8:0] d);
    @(posedge i_core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {23'h000000, d};
    do @(posedge i_core_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    wb(1'b0, a, 9'h000);
    chk(q, exp);
  endtask : rd
  task automatic wrc(input logic [6:0] i, input logic [8:0] d);
    wb(1'b1, a4(i), d);
    rd(a4(i), {23'h000000, d});
  endtask : wrc
  task automatic pulse();
    @(posedge i_core_clk);
    sv <= 1'b1;
    @(posedge i_core_clk);
    sv <= 1'b0;
    #1;
  endtask : pulse
  task automatic run(input int n);
    logic pc;
    int t;
    pc = dclk;
    t = 0;
    n_l = 0;
    n_r = 0;
    n_hi = 0;
    for (int c = 1; c <= n; c++) begin
      step(1);
      n_hi += int'(dclk);
      if (dclk !== pc) begin
        if (t > 0) chk({31'h0, (c - t > 15) && (c - t < 63)}, 32'h1);
        t = c;
        pc = dclk;
      end
      if (lval === 1'b1) begin
        n_l++;
        chk({30'h0, dclk, lbit}, {30'h0, 1'b1, ~ml});
      end
      if (rval === 1'b1) begin
        n_r++;
        chk({30'h0, dclk, rbit}, {30'h0, 1'b0, mr});
      end
    end
  endtask : run

  // --------------------------------------------
  // Clock, reset, watchdog and tests
  // --------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    {i_reset_n, cyc, stb, we, sv, adr, wdat, lin, rin} = '0;
    {sel, pwr, sw, alc_l, alc_r} = {4'hf, 4'hf, 16'hffff, 8'h5a, 8'h6b};
    repeat (3) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    step(1);
    chk({24'h0, lvol}, 32'hff);
    rd(a4(aip_pkg::IDX_VOL_LEFT), 32'h0ff);
    wb(1'b1, 32'h218, 9'h1ff);
    rd(32'h218, 32'h0);
    rd(a4(aip_pkg::IDX_BIAS_ADC), 32'h0);
    $display("test reset and unmapped done");
    for (int k = 0; k < 8; k++) begin
      wrc(aip_pkg::IDX_BIAS_ADC, {7'h0, k[1:0]});
      wrc(aip_pkg::IDX_BIAS_MODE, {4'h0, k[2], 4'h0});
      step(2);
      chk({29'h0, bcfg}, {29'h0, k[1:0], k[2]});
    end
    $display("test bias done");
    for (int k = 0; k < 2; k++) begin
      wrc(aip_pkg::IDX_HPF_OSR, k[0] ? 9'h0b8 : 9'h000);
      wrc(aip_pkg::IDX_SAMPLE_RATE, k[0] ? 9'h00a : 9'h000);
      wrc(aip_pkg::IDX_POL_FILT, {8'h0, ~k[0]});
      step(2);
      chk({23'h0, fcfg}, k[0] ? 32'h1bb : 32'h0);
    end
    $display("test filter done");
    wrc(aip_pkg::IDX_BIAS_ADC, 9'h00c);
    step(2);
    chk({30'h0, lrun, rrun}, 32'h3);
    lin <= 24'h123456;
    rin <= 24'h800000;
    for (int p = 0; p < 4; p++) begin
      wrc(aip_pkg::IDX_POL_FILT, {2'h0, p[1:0], 5'h0});
      step(2);
      pulse();
      chk({31'h0, osv}, 32'h1);
      chk({8'h0, lout}, p[0] ? 32'hedcbaa : 32'h123456);
      chk({8'h0, rout}, p[1] ? 32'h7fffff : 32'h800000);
    end
    wrc(aip_pkg::IDX_BIAS_ADC, 9'h004);
    step(2);
    pulse();
    chk({6'h0, lrun, rrun, lout}, 32'h1000000);
    $display("test sample path done");
    wb(1'b1, a4(aip_pkg::IDX_VOL_LEFT), 9'h033);
    wb(1'b1, a4(aip_pkg::IDX_VOL_RIGHT), 9'h144);
    step(2);
    chk({16'h0, lvol, rvol}, 32'h3344);
    wrc(aip_pkg::IDX_LEVEL_CTRL, 9'h080);
    step(2);
    chk({16'h0, lvol, rvol}, 32'h5a6b);
    pwr <= 4'b0101;
    sw <= 16'h0f10;
    wrc(aip_pkg::IDX_REF_BUF, 9'h100);
    step(2);
    chk({23'h0, refb, otie, itie}, 32'h1a9);
    $display("test volume and tie-off done");
    wrc(aip_pkg::IDX_POL_FILT, 9'h020);
    wrc(aip_pkg::IDX_PIN_CTRL, 9'h001);
    wrc(aip_pkg::IDX_DMIC_EN, 9'h030);
    run(700);
    chk({31'h0, doe}, 32'h1);
    chk({31'h0, n_l > 9 && n_r > 9}, 32'h1);
    wrc(aip_pkg::IDX_DMIC_EN, 9'h010);
    run(400);
    chk({31'h0, n_l > 4 && n_r == 0}, 32'h1);
    wrc(aip_pkg::IDX_DMIC_EN, 9'h000);
    step(2);
    run(200);
    chk({n_hi[15:0], n_l[7:0], n_r[7:0]}, 32'h0);
    $display("test microphone link done");
    finish_test();
  end
endmodule : test_audio_adc_input_path_control
